// [tb/jrcpct_host.sv]
// Behavioural JTAG host that paces the test access pins from the system clock.
`timescale 1ns/1ps
module jrcpct_host (
    // Pacing clock.
    input wire logic clock,
    // JTAG pins.
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    initial {tck, tms, tdi} = 3'h2;
    // Long TCK phases, because the port oversamples TCK and answers three clocks late.
    task automatic step(input logic m, input logic d, output logic o);
        @(negedge clock);
        {tck, tms, tdi} = {1'b0, m, d};
        repeat (5) @(negedge clock);
        o = tdo;
        tck = 1'b1;
        repeat (4) @(negedge clock);
    endtask
    // Five ones reach Test-Logic-Reset from any state, then park in Idle.
    task automatic reset_tap();
        logic o;
        repeat (5) step(1'b1, ~tdi, o);
        step(1'b0, ~tdi, o);
    endtask
    // Shifts n bits least significant first from Idle and returns to Idle.
    task automatic scan(input logic ir, input int n, input logic [39:0] din,
        output logic [39:0] dout);
        logic o;
        dout = '0;
        step(1'b1, ~tdi, o);
        if (ir) step(1'b1, ~tdi, o);
        step(1'b0, ~tdi, o);
        step(1'b0, ~tdi, o);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        step(1'b1, ~tdi, o);
        step(1'b0, ~tdi, o);
    endtask
endmodule

// [tb/jrcpct_properties.sv]
// Concurrent checks on the reset control and pin chain test ports.
`timescale 1ns/1ps
module jrcpct_properties
    import jrcpct_pkg::*;
(
    // Clock and resets.
    input wire logic clock,
    input wire logic resetn,
    input wire logic powerGood,
    input wire logic trstn,
    // Watched pins.
    input wire logic tck,
    input wire logic tdoEnable,
    input wire logic [CHAIN_PINS-1:0] chainPins,
    input wire logic chainMode,
    input wire logic chain_result_pin,
    input wire logic hostResetForce,
    input wire logic standbyResetForce,
    input wire logic core_reset_shorten
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    // TCK is oversampled, so eight quiet clocks let any pending update land first.
    sequence tckQuiet; (trstn && powerGood && $stable(tck))[*8]; endsequence
    sequence pinsSteady; (chainMode && $stable(chainPins))[*5]; endsequence
    sequence trstHeld; (!trstn)[*4]; endsequence
    reset_clears_a:
        assert property (disable iff (1'b0) !resetn |=> !chainMode && !hostResetForce
            && !standbyResetForce && !core_reset_shorten && chain_result_pin)
        else $error("outputs not cleared by reset");
    trst_clears_a:
        assert property (trstHeld |-> ##[0:4]
            !(hostResetForce || standbyResetForce || core_reset_shorten))
        else $error("outputs not cleared by test reset");
    update_only_a:
        assert property (tckQuiet |->
            $stable({hostResetForce, standbyResetForce, core_reset_shorten}))
        else $error("reset outputs moved without a scan");
    shift_gate_a:
        assert property (tckQuiet |-> $stable(tdoEnable)) else $error("tdo enable moved");
    chain_xnor_a:
        assert property (pinsSteady |-> chain_result_pin == ~^chainPins)
        else $error("chain result is not even parity");
    chain_sticky_a:
        assert property (chainMode && powerGood |=> chainMode) else $error("chain mode left");
    chain_quiet_a:
        assert property (chainMode |-> !tdoEnable) else $error("tdo driven in chain mode");
    chain_exit_a:
        assert property ((!powerGood)[*5] |-> !chainMode) else $error("power cycle ignored");
endmodule
bind jrcpct_top jrcpct_properties jrcpct_properties_inst (.clock, .resetn, .powerGood,
    .trstn, .tck, .tdoEnable, .chainPins, .chainMode, .chain_result_pin, .hostResetForce,
    .standbyResetForce, .core_reset_shorten);

// [tb/tb_top.sv]
// Self-checking bench for the reset control and pin chain test block.
`timescale 1ns/1ps
module tb_top
    import jrcpct_pkg::*;
;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic powerGood = 1'b1;
    logic trstn = 1'b0;
    logic [CHAIN_PINS-1:0] chainPins = '0;
    logic tck, tms, tdi, tdo, tdoEnable, chainMode, chain_result_pin;
    logic hostResetForce, standbyResetForce, core_reset_shorten;
    logic tdoPin;
    logic [31:0] seed = 32'hA166BFA5;
    logic [31:0] modelDh, wdata, prev;
    logic [39:0] got;
    int err_total = 0;
    int num_checks = 0;
    int cycles = 0;
    jrcpct_top jrcpct_top_inst (.clock, .resetn, .powerGood, .tck, .tms, .tdi, .trstn, .tdo,
        .tdoEnable, .chainPins, .chainMode, .chain_result_pin, .hostResetForce,
        .standbyResetForce, .core_reset_shorten);
    // A released TDO floats to the host's pull-up, so a stale bit is never seen.
    assign tdoPin = tdoEnable ? tdo : 1'b1;
    jrcpct_host jrcpct_host_inst (.clock, .tck, .tms, .tdi, .tdo(tdoPin));
    always #12.5 clock = ~clock;
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            err_total++;
            finish_test();
        end
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input string what, input logic [39:0] exp, input logic [39:0] seen);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic access(input logic [3:0] code, input logic [31:0] data);
        jrcpct_host_inst.scan(1'b1, 4, {36'h0, code}, got);
        jrcpct_host_inst.scan(1'b0, 32, {8'h00, data}, got);
    endtask
    task automatic finish_test();
        $display("Checks %0d, errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(negedge clock);
        {resetn, trstn} = 2'h3;
        @(negedge clock);
        check("reset outputs", 40'h1, 40'({hostResetForce, standbyResetForce,
            core_reset_shorten, chainMode, chain_result_pin}));
        jrcpct_host_inst.reset_tap();
        jrcpct_host_inst.scan(1'b0, 40, 40'hFF, got);
        check("discovery", {8'hFF, IDENT_VALUE}, got);
        check("ident marks", 40'h1, 40'({got[11:0] == 12'h0FF, got[0]}));
        check("chain end marker", 40'hFF, 40'(got[39:32]));
        for (int c = 0; c < 16; c++) begin
            if (c inside {2, 12, 13}) continue;
            jrcpct_host_inst.scan(1'b1, 4, 40'(c), got);
            jrcpct_host_inst.scan(1'b0, 2, 40'h3, got);
            check("bypass", 40'h2, got);
        end
        prev = '0;
        for (int i = 5; i < 13; i++) begin
            access(IR_RESET_TEST, 32'(i % 8) << 1);
            check("reset test readback", 40'(prev & RESET_TEST_WMASK), got);
            prev = 32'(i % 8) << 1;
            check("host force", 40'(prev[3] & ~prev[1]), 40'(hostResetForce));
            check("standby force", 40'(prev[3] & ~prev[2]), 40'(standbyResetForce));
        end
        modelDh = '0;
        repeat (6) begin
            wdata = rnd() & ~32'h2;
            access(IR_RESET_CHAIN, wdata);
            check("chain ctl readback", 40'(modelDh), got);
            modelDh = wdata & RESET_CHAIN_WMASK;
            check("core reset shorten", 40'(wdata[0]), 40'(core_reset_shorten));
            check("chain mode off", 40'h0, 40'(chainMode));
        end
        trstn = 1'b0;
        repeat (8) @(negedge clock);
        trstn = 1'b1;
        check("test reset", 40'h0, 40'({hostResetForce, standbyResetForce,
            core_reset_shorten}));
        // Test reset parks the port in Test-Logic-Reset, so walk it back to Idle first.
        jrcpct_host_inst.reset_tap();
        access(IR_RESET_CHAIN, 32'h2);
        check("chain ctl cleared", 40'h0, got);
        @(negedge clock);
        check("chain mode on", 40'h1, 40'(chainMode));
        for (int j = 0; j < 2 * CHAIN_PINS + 3; j++) begin
            if (j < CHAIN_PINS) chainPins[CHAIN_PINS - 1 - j] = 1'b1;
            else if (j < 2 * CHAIN_PINS) chainPins[j - CHAIN_PINS] = 1'b0;
            else chainPins = CHAIN_PINS'(rnd());
            repeat (6) @(negedge clock);
            check("chain result", 40'($countones(chainPins) % 2 == 0),
                40'(chain_result_pin));
        end
        access(IR_RESET_CHAIN, 32'h0);
        check("chain mode kept", 40'h1, 40'(chainMode));
        powerGood = 1'b0;
        repeat (8) @(negedge clock);
        powerGood = 1'b1;
        repeat (6) @(negedge clock);
        check("chain mode power cycle", 40'h0, 40'(chainMode));
        jrcpct_host_inst.reset_tap();
        access(IR_RESET_CHAIN, 32'h0);
        check("chain ctl after power", 40'h0, got);
        check("chain mode stays off", 40'h0, 40'(chainMode));
        finish_test();
    end
endmodule

// [verilog/jrcpct_pkg.sv]
// Package with constants for the JTAG reset control and pin chain test block.
package jrcpct_pkg;
    localparam int IR_WIDTH = 4;
    localparam logic [3:0] IR_RESET_TEST = 4'h2;
    localparam logic [3:0] IR_IDENT = 4'hC;
    localparam logic [3:0] IR_RESET_CHAIN = 4'hD;
    localparam logic [3:0] IR_BYPASS = 4'hF;
    localparam logic [31:0] RESET_CHAIN_RESET = 32'h00000000;
    localparam logic [31:0] RESET_TEST_RESET = 32'h00000000;
    // Writable bits of the reset and chain test control register.
    localparam logic [31:0] RESET_CHAIN_WMASK = 32'h003FCF1F;
    // Writable bits of the forced reset test control register.
    localparam logic [31:0] RESET_TEST_WMASK = 32'h00FFE3FE;
    localparam int FLD_SHORTEN = 0;
    localparam int FLD_CHAIN_EN = 1;
    localparam int FLD_HOST_RESET = 1;
    localparam int FLD_STANDBY_RESET = 2;
    localparam int FLD_OVERRIDE_EN = 3;
    // Arbitrary neutral identification value; bit 0 is one as required.
    localparam logic [31:0] IDENT_VALUE = 32'h0A5A5001;
    localparam int CHAIN_PINS = 16;
    typedef enum logic [15:0] {
        TAP_RESET = 16'h0001, TAP_IDLE = 16'h0002, TAP_SEL_DR = 16'h0004,
        TAP_CAP_DR = 16'h0008, TAP_SHIFT_DR = 16'h0010, TAP_EXIT1_DR = 16'h0020,
        TAP_PAUSE_DR = 16'h0040, TAP_EXIT2_DR = 16'h0080, TAP_UPD_DR = 16'h0100,
        TAP_SEL_IR = 16'h0200, TAP_CAP_IR = 16'h0400, TAP_SHIFT_IR = 16'h0800,
        TAP_EXIT1_IR = 16'h1000, TAP_PAUSE_IR = 16'h2000, TAP_EXIT2_IR = 16'h4000,
        TAP_UPD_IR = 16'h8000
    } jrcpct_tap_t;
endpackage

// [verilog/jrcpct_top.sv]
// JTAG test data registers for forced resets, core reset shortening and pin chain test.
`timescale 1ns/1ps
// How it works
// - With override enabled, host-supply field zero forces host-supply reset.
// - With override enabled, standby field zero forces standby power-on reset.
// - Override enable bit gates both forced-reset fields; zero means no effect.
// - Register at code Dh is 32 bits, cleared to zero by JTAG reset.
// - Bit 0 set shortens core reset; clear keeps full nominal stretch.
// - Bit 1 set enables pin chain test mode; clear leaves it disabled.
// - Once chain mode is on, only a power cycle or system reset leaves it.
// - Test-Logic-Reset selects the identification register.
// - Identification register is 32 bits, bit 0 one, low 12 bits not FFh.
// - Bypass is one cell capturing zero.
// - Chain mode detaches pins and drives XNOR result on result pin.
// - Supply, regulator, reference, test reset and analog pins stay out of chain.
// - Chain output is even-parity XNOR of all chain inputs.
module jrcpct_top
    import jrcpct_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic resetn,
    input wire logic powerGood,
    // JTAG pins.
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic trstn,
    output logic tdo,
    output logic tdoEnable,
    // Chain pins; excluded analog and supply pins never reach this port.
    input wire logic [CHAIN_PINS-1:0] chainPins,
    output logic chainMode,
    output logic chain_result_pin,
    // Reset controls.
    output logic hostResetForce,
    output logic standbyResetForce,
    output logic core_reset_shorten
);
    logic [2:0] tckSync, tmsSync, tdiSync, trstSync;
    logic [CHAIN_PINS-1:0] pinMeta, pinSync;
    logic tckRise, tckFall;
    jrcpct_tap_t tapState, next_tapState;
    logic [IR_WIDTH-1:0] irShift, irReg;
    logic [31:0] drShift, resetChain, resetTest;
    logic chainLatched;
    logic [1:0] pgSync;

    // Two flops before use; the third stage only feeds edge detection.
    always_ff @(posedge clock) begin
        if (!resetn) begin
            tckSync <= 3'h0;
            tmsSync <= 3'h0;
            tdiSync <= 3'h0;
            trstSync <= 3'h0;
        end else begin
            tckSync <= {tckSync[1:0], tck};
            tmsSync <= {tmsSync[1:0], tms};
            tdiSync <= {tdiSync[1:0], tdi};
            trstSync <= {trstSync[1:0], trstn};
        end
    end
    assign tckRise = tckSync[1] & ~tckSync[2];
    assign tckFall = ~tckSync[1] & tckSync[2];

    // Supply-good is a pin as well, so it passes two flops before any logic reads it.
    always_ff @(posedge clock) begin
        if (!resetn) begin
            pgSync <= 2'h3;
        end else begin
            pgSync <= {pgSync[0], powerGood};
        end
    end

    always_comb begin
        next_tapState = tapState;
        unique case (tapState)
            TAP_RESET: next_tapState = tmsSync[1] ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: next_tapState = tmsSync[1] ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: next_tapState = tmsSync[1] ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: next_tapState = tmsSync[1] ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: next_tapState = tmsSync[1] ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: next_tapState = tmsSync[1] ? TAP_UPD_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR: next_tapState = tmsSync[1] ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: next_tapState = tmsSync[1] ? TAP_UPD_DR : TAP_SHIFT_DR;
            TAP_UPD_DR: next_tapState = tmsSync[1] ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: next_tapState = tmsSync[1] ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR: next_tapState = tmsSync[1] ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: next_tapState = tmsSync[1] ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: next_tapState = tmsSync[1] ? TAP_UPD_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR: next_tapState = tmsSync[1] ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: next_tapState = tmsSync[1] ? TAP_UPD_IR : TAP_SHIFT_IR;
            TAP_UPD_IR: next_tapState = tmsSync[1] ? TAP_SEL_DR : TAP_IDLE;
            default: next_tapState = TAP_RESET;
        endcase
    end

    // The port is dead while chain mode holds, so no state advances.
    always_ff @(posedge clock) begin
        if (!resetn || !trstSync[1] || !pgSync[1]) begin
            tapState <= TAP_RESET;
        end else if (tckRise && !chainLatched) begin
            tapState <= next_tapState;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn || !trstSync[1] || !pgSync[1]) begin
            irShift <= IR_IDENT;
            irReg <= IR_IDENT;
        end else if (tckRise && !chainLatched) begin
            if (tapState == TAP_RESET) begin
                irReg <= IR_IDENT;
            end else if (tapState == TAP_CAP_IR) begin
                irShift <= 4'h1;
            end else if (tapState == TAP_SHIFT_IR) begin
                irShift <= {tdiSync[1], irShift[IR_WIDTH-1:1]};
            end else if (tapState == TAP_UPD_IR) begin
                irReg <= irShift;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            drShift <= 32'h00000000;
        end else if (tckRise && !chainLatched) begin
            if (tapState == TAP_CAP_DR) begin
                unique case (irReg)
                    IR_IDENT: drShift <= IDENT_VALUE;
                    IR_RESET_CHAIN: drShift <= resetChain;
                    IR_RESET_TEST: drShift <= resetTest;
                    default: drShift <= 32'h00000000;
                endcase
            end else if (tapState == TAP_SHIFT_DR) begin
                // Bypass is one cell: only the LSB position shifts toward output.
                if (irReg == IR_IDENT || irReg == IR_RESET_CHAIN || irReg == IR_RESET_TEST) begin
                    drShift <= {tdiSync[1], drShift[31:1]};
                end else begin
                    drShift <= {31'h00000000, tdiSync[1]};
                end
            end
        end
    end

    // JTAG reset or a supply cycle clears both registers; otherwise a set
    // chain enable bit would latch chain mode again right after power returns.
    always_ff @(posedge clock) begin
        if (!resetn || !trstSync[1] || !pgSync[1]) begin
            resetChain <= RESET_CHAIN_RESET;
            resetTest <= RESET_TEST_RESET;
        end else if (tckRise && !chainLatched && tapState == TAP_UPD_DR) begin
            if (irReg == IR_RESET_CHAIN) begin
                resetChain <= (drShift & RESET_CHAIN_WMASK)
                    | (resetChain & ~RESET_CHAIN_WMASK);
            end
            if (irReg == IR_RESET_TEST) begin
                resetTest <= (drShift & RESET_TEST_WMASK)
                    | (resetTest & ~RESET_TEST_WMASK);
            end
        end
    end

    // Only system reset or a loss of power clears chain mode; JTAG reset cannot.
    always_ff @(posedge clock) begin
        if (!resetn || !pgSync[1]) begin
            chainLatched <= 1'b0;
        end else if (resetChain[FLD_CHAIN_EN]) begin
            chainLatched <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            pinMeta <= '0;
            pinSync <= '0;
        end else begin
            pinMeta <= chainPins;
            pinSync <= pinMeta;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            chainMode <= 1'b0;
            chain_result_pin <= 1'b1;
        end else begin
            chainMode <= chainLatched;
            chain_result_pin <= ~(^pinSync);
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            hostResetForce <= 1'b0;
            standbyResetForce <= 1'b0;
            core_reset_shorten <= 1'b0;
        end else begin
            hostResetForce <= resetTest[FLD_OVERRIDE_EN] && !resetTest[FLD_HOST_RESET];
            standbyResetForce <= resetTest[FLD_OVERRIDE_EN]
                && !resetTest[FLD_STANDBY_RESET];
            core_reset_shorten <= resetChain[FLD_SHORTEN];
        end
    end

    // TDO changes on the falling TCK edge, as the scan convention expects.
    always_ff @(posedge clock) begin
        if (!resetn) begin
            tdo <= 1'b0;
            tdoEnable <= 1'b0;
        end else if (tckFall) begin
            tdo <= (tapState == TAP_SHIFT_IR) ? irShift[0] : drShift[0];
            tdoEnable <= !chainLatched
                && (tapState == TAP_SHIFT_DR || tapState == TAP_SHIFT_IR);
        end
    end
endmodule
